/* hdl/ddc_driver_config.sv */
`timescale 1ns/10ps
`default_nettype none
module ddc_driver_config
  import ddc_pkg::*;
#(
  parameter int unsigned IDLE_MAX_LOG2 = IDLE_LOG2_MAX
) (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  // register port
  input  wire logic [REG_ADDR_W-1:0] reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic [REG_DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_rd,
  output logic      [REG_DATA_W-1:0] reg_rdata,
  output logic                       reg_rvalid,
  // step pulses
  input  wire logic                  axis0_step,
  input  wire logic                  axis1_step,
  // reference switches
  input  wire logic                  axis0_left_switch,
  input  wire logic                  axis0_right_switch,
  input  wire logic                  axis1_left_switch,
  input  wire logic                  axis1_right_switch,
  // standstill and driver disable
  output logic                       axis0_idle,
  output logic                       axis1_idle,
  output logic                       axis0_driver_halt,
  output logic                       axis1_driver_halt,
  // current scaling
  output logic      [SCALE_W-1:0]    axis0_refcurrent_scale,
  output logic      [SCALE_W-1:0]    axis1_refcurrent_scale,
  output logic      [SCALE_W-1:0]    axis0_sense_range,
  output logic      [SCALE_W-1:0]    axis1_sense_range,
  output logic      [SCALE_W-1:0]    axis0_overcurrent_sel,
  output logic      [SCALE_W-1:0]    axis1_overcurrent_sel,
  output logic      [GAIN_W-1:0]     axis0_range_gain_factor,
  output logic      [GAIN_W-1:0]     axis1_range_gain_factor
);
  logic                  rst_meta_b;
  logic                  rst_sync_b;
  logic [REG_DATA_W-1:0] driver_configuration;
  logic                  cfg_hit;
  logic [SCALE_W-1:0]    range0;
  logic [SCALE_W-1:0]    range1;

  ddc_axis_if ax0 ();
  ddc_axis_if ax1 ();

  // release of reset goes through two flops
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  assign cfg_hit = (reg_addr == DRIVER_CONFIGURATION);

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      driver_configuration <= CFG_RESET;
    end else if (reg_wr && cfg_hit) begin
      driver_configuration <= reg_wdata & CFG_WRITE_MASK;
    end
  end

  // read returns pre-write value when both strobes coincide
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= cfg_hit ? driver_configuration : '0;
      end
    end
  end

  // per-axis wiring
  assign ax0.idle_delay_sel  =
    driver_configuration[AX0_IDLE_LSB +: IDLE_SEL_W];
  assign ax1.idle_delay_sel  =
    driver_configuration[AX1_IDLE_LSB +: IDLE_SEL_W];
  assign ax0.step            = axis0_step;
  assign ax1.step            = axis1_step;
  assign ax0.halt_enable     = driver_configuration[AX0_HALT_EN_BIT];
  assign ax1.halt_enable     = driver_configuration[AX1_HALT_EN_BIT];
  assign ax0.halt_source_sel = driver_configuration[AX0_HALT_SRC_BIT];
  assign ax1.halt_source_sel = driver_configuration[AX1_HALT_SRC_BIT];
  assign ax0.own_left        = axis0_left_switch;
  assign ax0.own_right       = axis0_right_switch;
  assign ax0.other_left      = axis1_left_switch;
  assign ax0.other_right     = axis1_right_switch;
  assign ax1.own_left        = axis1_left_switch;
  assign ax1.own_right       = axis1_right_switch;
  assign ax1.other_left      = axis0_left_switch;
  assign ax1.other_right     = axis0_right_switch;

  ddc_idle_timer #(.MAX_LOG2(IDLE_MAX_LOG2)) u_idle0 (
    .clock      (clock),
    .rst_sync_b (rst_sync_b),
    .ax         (ax0.timer)
  );
  ddc_idle_timer #(.MAX_LOG2(IDLE_MAX_LOG2)) u_idle1 (
    .clock      (clock),
    .rst_sync_b (rst_sync_b),
    .ax         (ax1.timer)
  );
  ddc_halt_logic u_halt0 (
    .clock      (clock),
    .rst_sync_b (rst_sync_b),
    .ax         (ax0.halter)
  );
  ddc_halt_logic u_halt1 (
    .clock      (clock),
    .rst_sync_b (rst_sync_b),
    .ax         (ax1.halter)
  );

  assign axis0_idle        = ax0.idle;
  assign axis1_idle        = ax1.idle;
  assign axis0_driver_halt = ax0.halt;
  assign axis1_driver_halt = ax1.halt;

  // scale codes straight from the register
  assign axis0_refcurrent_scale =
    driver_configuration[AX0_REFCUR_LSB +: SCALE_W];
  assign axis1_refcurrent_scale =
    driver_configuration[AX1_REFCUR_LSB +: SCALE_W];

  assign range0 = driver_configuration[AX0_RANGE_LSB +: SCALE_W];
  assign range1 = driver_configuration[AX1_RANGE_LSB +: SCALE_W];

  assign axis0_sense_range     = range0;
  assign axis1_sense_range     = range1;
  assign axis0_overcurrent_sel = range0;
  assign axis1_overcurrent_sel = range1;

  // gain lookup, one cycle behind the range
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      axis0_range_gain_factor <= GAIN_X100[0];
      axis1_range_gain_factor <= GAIN_X100[0];
    end else begin
      axis0_range_gain_factor <= GAIN_X100[range0];
      axis1_range_gain_factor <= GAIN_X100[range1];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_b);

  a_reserved_read_zero: assert property (
    reg_rvalid |-> (reg_rdata & ~CFG_WRITE_MASK) == '0)
    else $error("reserved bits read nonzero");
  a_cfg_write_read: assert property (
    reg_wr && cfg_hit ##1 reg_rd && cfg_hit && !reg_wr
      |=> reg_rdata == ($past(reg_wdata, 2) & CFG_WRITE_MASK))
    else $error("written value not read back");
  a_refcur_forward: assert property (
    reg_wr && cfg_hit |=>
      axis1_refcurrent_scale == $past(reg_wdata[AX1_REFCUR_LSB +: SCALE_W]) &&
      axis0_refcurrent_scale == $past(reg_wdata[AX0_REFCUR_LSB +: SCALE_W]))
    else $error("current scale not forwarded");
  a_gain_lookup: assert property (
    $past(rst_sync_b) |->
      axis1_range_gain_factor == GAIN_X100[$past(range1)] &&
      axis0_range_gain_factor == GAIN_X100[$past(range0)] &&
      axis0_overcurrent_sel == range0)
    else $error("gain factor does not follow range");
  a_gain_after_write: assert property (
    reg_wr && cfg_hit |-> ##2
      axis1_range_gain_factor ==
        GAIN_X100[$past(reg_wdata[AX1_RANGE_LSB +: SCALE_W], 2)] &&
      axis0_range_gain_factor ==
        GAIN_X100[$past(reg_wdata[AX0_RANGE_LSB +: SCALE_W], 2)])
    else $error("gain factor not set by write");

  a_rvalid_follows_read: assert property (
    reg_rd |=> reg_rvalid)
    else $error("read not acknowledged");
  a_rvalid_single_pulse: assert property (
    !reg_rd |=> !reg_rvalid)
    else $error("read valid without read");
  a_rdata_holds_value: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  a_read_other_zero: assert property (
    reg_rd && !cfg_hit |=> reg_rdata == '0)
    else $error("other index read nonzero");
  a_read_old_value: assert property (
    reg_rd && cfg_hit |=> reg_rdata == $past(driver_configuration))
    else $error("read data not register value");
  a_write_masked_store: assert property (
    reg_wr && cfg_hit |=>
      driver_configuration == ($past(reg_wdata) & CFG_WRITE_MASK))
    else $error("write not stored under mask");
  a_write_other_ignored: assert property (
    reg_wr && !cfg_hit |=> $stable(driver_configuration))
    else $error("write to other index changed register");
  a_cfg_hold_idle: assert property (
    !reg_wr |=> $stable(driver_configuration))
    else $error("register changed without write");
  a_cfg_reserved_zero: assert property (
    (driver_configuration & ~CFG_WRITE_MASK) == '0)
    else $error("reserved register bits set");

  // scale codes change only on writes
  a_scale_stable_idle: assert property (
    !(reg_wr && cfg_hit) |=>
      $stable(axis0_refcurrent_scale) && $stable(axis1_refcurrent_scale))
    else $error("current scale moved without write");

  // range and overcurrent level follow writes
  a_range_follows_write: assert property (
    reg_wr && cfg_hit |=>
      axis1_sense_range == $past(reg_wdata[AX1_RANGE_LSB +: SCALE_W]) &&
      axis0_sense_range == $past(reg_wdata[AX0_RANGE_LSB +: SCALE_W]))
    else $error("sense range not forwarded");
  a_overcurrent_follows_write: assert property (
    reg_wr && cfg_hit |=>
      axis1_overcurrent_sel == $past(reg_wdata[AX1_RANGE_LSB +: SCALE_W]) &&
      axis0_overcurrent_sel == $past(reg_wdata[AX0_RANGE_LSB +: SCALE_W]))
    else $error("overcurrent level not forwarded");
  a_range_stable_idle: assert property (
    !(reg_wr && cfg_hit) |=>
      $stable(axis0_sense_range) && $stable(axis1_sense_range) &&
      $stable(axis0_overcurrent_sel) && $stable(axis1_overcurrent_sel))
    else $error("sense range moved without write");

  // a step clears standstill on its own axis only
  a_idle0_step_clear: assert property (
    axis0_step |=> !axis0_idle)
    else $error("axis 0 standstill kept after step");
  a_idle1_step_clear: assert property (
    axis1_step |=> !axis1_idle)
    else $error("axis 1 standstill kept after step");

  // standstill holds while settings stay put
  a_idle1_holds_level: assert property (
    axis1_idle && !axis1_step && $stable(driver_configuration)
      |=> axis1_idle)
    else $error("axis 1 standstill dropped without step");
  a_idle0_holds_level: assert property (
    axis0_idle && !axis0_step && $stable(driver_configuration)
      |=> axis0_idle)
    else $error("axis 0 standstill dropped without step");

  // own switch pair disables the enabled driver
  a_halt1_own_pair: assert property (
    driver_configuration[AX1_HALT_EN_BIT] &&
      axis1_left_switch && axis1_right_switch |=> axis1_driver_halt)
    else $error("axis 1 own pair did not halt");
  a_halt0_own_pair: assert property (
    driver_configuration[AX0_HALT_EN_BIT] &&
      axis0_left_switch && axis0_right_switch |=> axis0_driver_halt)
    else $error("axis 0 own pair did not halt");
  a_halt1_off_state: assert property (
    !driver_configuration[AX1_HALT_EN_BIT] |=> !axis1_driver_halt)
    else $error("axis 1 halted while function off");
  a_halt0_off_state: assert property (
    !driver_configuration[AX0_HALT_EN_BIT] |=> !axis0_driver_halt)
    else $error("axis 0 halted while function off");

  // source select adds the other axis pair
  a_halt1_cross_pair: assert property (
    driver_configuration[AX1_HALT_EN_BIT] &&
      driver_configuration[AX1_HALT_SRC_BIT] &&
      axis0_left_switch && axis0_right_switch |=> axis1_driver_halt)
    else $error("axis 1 cross pair did not halt");
  a_halt0_cross_pair: assert property (
    driver_configuration[AX0_HALT_EN_BIT] &&
      driver_configuration[AX0_HALT_SRC_BIT] &&
      axis1_left_switch && axis1_right_switch |=> axis0_driver_halt)
    else $error("axis 0 cross pair did not halt");
  a_halt1_local_only: assert property (
    !driver_configuration[AX1_HALT_SRC_BIT] &&
      !(axis1_left_switch && axis1_right_switch) |=> !axis1_driver_halt)
    else $error("axis 1 halted without own pair");
  a_halt0_local_only: assert property (
    !driver_configuration[AX0_HALT_SRC_BIT] &&
      !(axis0_left_switch && axis0_right_switch) |=> !axis0_driver_halt)
    else $error("axis 0 halted without own pair");
endmodule : ddc_driver_config
`default_nettype wire

/* hdl/ddc_pkg.sv */
`default_nettype none
package ddc_pkg;
  // clock
  localparam int unsigned CLK_PERIOD_NS        = 4;
  // register port
  localparam int unsigned REG_ADDR_W           = 7;
  localparam int unsigned REG_DATA_W           = 32;
  localparam logic [6:0]  DRIVER_CONFIGURATION = 7'h05;
  localparam logic [31:0] CFG_RESET            = 32'h0000_0000;
  localparam logic [31:0] CFG_WRITE_MASK       = 32'h0077_0fff;
  // field positions
  localparam int unsigned AX1_IDLE_LSB         = 20;
  localparam int unsigned AX0_IDLE_LSB         = 16;
  localparam int unsigned AX1_HALT_SRC_BIT     = 11;
  localparam int unsigned AX1_HALT_EN_BIT      = 10;
  localparam int unsigned AX1_REFCUR_LSB       = 8;
  localparam int unsigned AX1_RANGE_LSB        = 6;
  localparam int unsigned AX0_HALT_SRC_BIT     = 5;
  localparam int unsigned AX0_HALT_EN_BIT      = 4;
  localparam int unsigned AX0_REFCUR_LSB       = 2;
  localparam int unsigned AX0_RANGE_LSB        = 0;
  localparam int unsigned IDLE_SEL_W           = 3;
  localparam int unsigned SCALE_W              = 2;
  // standstill timing: 2^(IDLE_LOG2_MAX - n) cycles
  localparam int unsigned IDLE_LOG2_MAX        = 20;
  localparam int unsigned IDLE_CNT_W           = 21;
  localparam int unsigned IDLE_SHIFT_W         = 5;
  // gain factor of each sense range, times 100
  localparam int unsigned GAIN_W               = 10;
  localparam logic [9:0]  GAIN_X100 [4]        = '{10'h0cd, 10'h198,
                                                   10'h25b, 10'h320};
endpackage : ddc_pkg
`default_nettype wire

/* hdl/ddc_axis_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface ddc_axis_if;
  import ddc_pkg::*;
  logic [IDLE_SEL_W-1:0] idle_delay_sel;
  logic                  step;
  logic                  idle;
  logic                  halt_enable;
  logic                  halt_source_sel;
  logic                  own_left;
  logic                  own_right;
  logic                  other_left;
  logic                  other_right;
  logic                  halt;

  modport timer (input idle_delay_sel, input step, output idle);
  modport halter (input halt_enable, input halt_source_sel,
                  input own_left, input own_right,
                  input other_left, input other_right, output halt);
  modport owner (output idle_delay_sel, output step,
                 output halt_enable, output halt_source_sel,
                 output own_left, output own_right,
                 output other_left, output other_right,
                 input idle, input halt);
endinterface : ddc_axis_if
`default_nettype wire

/* hdl/ddc_idle_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module ddc_idle_timer
  import ddc_pkg::*;
#(
  parameter int unsigned MAX_LOG2 = IDLE_LOG2_MAX
) (
  // clock and reset
  input  wire logic  clock,
  input  wire logic  rst_sync_b,
  // axis signals
  ddc_axis_if.timer  ax
);
  logic [IDLE_CNT_W-1:0]   count;
  logic [IDLE_CNT_W-1:0]   next_count;
  logic [IDLE_CNT_W-1:0]   thr;
  logic [IDLE_SHIFT_W-1:0] shift;
  logic [IDLE_SHIFT_W-1:0] max_log2;

  // a shortened MAX_LOG2 below the field value clamps to one cycle
  always_comb begin
    max_log2 = IDLE_SHIFT_W'(MAX_LOG2);
    if (max_log2 >= IDLE_SHIFT_W'(ax.idle_delay_sel)) begin
      shift = max_log2 - IDLE_SHIFT_W'(ax.idle_delay_sel);
    end else begin
      shift = '0;
    end
    thr = IDLE_CNT_W'(1) << shift;
  end

  always_comb begin
    if (ax.step) begin
      next_count = '0;
    end else if (count < thr) begin
      next_count = count + IDLE_CNT_W'(1);
    end else begin
      next_count = count;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ax.idle <= 1'b0;
    end else begin
      ax.idle <= !ax.step && (next_count >= thr);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_b);

  a_idle_step_clear: assert property (
    ax.step |=> !ax.idle && (count == '0))
    else $error("standstill not cleared by step");
  a_idle_reach_thr: assert property (
    !ax.step && (count == thr - IDLE_CNT_W'(1)) && $stable(thr)
      |=> ax.idle)
    else $error("standstill late after threshold");
  // a raised threshold takes effect one edge late
  a_idle_not_early: assert property (
    ax.idle && $stable(thr) |-> count >= thr)
    else $error("standstill before threshold");
endmodule : ddc_idle_timer
`default_nettype wire

/* hdl/ddc_halt_logic.sv */
`timescale 1ns/10ps
`default_nettype none
module ddc_halt_logic
  import ddc_pkg::*;
(
  // clock and reset
  input  wire logic  clock,
  input  wire logic  rst_sync_b,
  // axis signals
  ddc_axis_if.halter ax
);
  logic own_pair;
  logic other_pair;

  assign own_pair   = ax.own_left && ax.own_right;
  assign other_pair = ax.other_left && ax.other_right;

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ax.halt <= 1'b0;
    end else begin
      ax.halt <= ax.halt_enable &&
                 (own_pair || (ax.halt_source_sel && other_pair));
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_b);

  a_halt_own_pair: assert property (
    ax.halt_enable && own_pair |=> ax.halt)
    else $error("own switch pair did not disable driver");
  a_halt_disabled: assert property (
    !ax.halt_enable |=> !ax.halt)
    else $error("driver disabled while function off");
  a_halt_cross_pair: assert property (
    ax.halt_enable && ax.halt_source_sel && other_pair |=> ax.halt)
    else $error("other axis pair did not disable driver");
  a_halt_local_only: assert property (
    !ax.halt_source_sel && !own_pair |=> !ax.halt)
    else $error("driver disabled without own pair");
endmodule : ddc_halt_logic
`default_nettype wire

/* tb/ddc_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ddc_host_model (
  // clock
  input  wire logic       clock,
  // step pulses
  output logic      [1:0] step,
  // reference switches, {r1, l1, r0, l0}
  output logic      [3:0] sw
);
  initial begin
    step = 2'h0;
    sw   = 4'h0;
  end

  // change away from the sampling edge
  task automatic set_sw(input logic [3:0] v);
    @(negedge clock);
    sw = v;
  endtask : set_sw

  // one-cycle step pulse
  task automatic pulse(input int ax);
    @(negedge clock);
    step[ax] = 1'b1;
    @(negedge clock);
    step[ax] = 1'b0;
  endtask : pulse
endmodule : ddc_host_model
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import ddc_pkg::*;
  // short standstill counts keep the run brief
  localparam int unsigned MAXL = 4;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic [6:0]  reg_addr;
  logic        reg_wr;
  logic [31:0] reg_wdata;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        reg_rvalid;
  logic [1:0]  step, idle, halt;
  logic [3:0]  sw;
  logic [1:0]  scl0, scl1, rng0, rng1, oc0, oc1;
  logic [9:0]  gn0, gn1;
  int          num_errors = 0;
  int          checked = 0;

  always #(CLK_PERIOD_NS / 2) clock = ~clock;

  ddc_driver_config #(.IDLE_MAX_LOG2(MAXL)) u_dut (
    .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .axis0_step(step[0]), .axis1_step(step[1]),
    .axis0_left_switch(sw[0]), .axis0_right_switch(sw[1]),
    .axis1_left_switch(sw[2]), .axis1_right_switch(sw[3]),
    .axis0_idle(idle[0]), .axis1_idle(idle[1]),
    .axis0_driver_halt(halt[0]), .axis1_driver_halt(halt[1]),
    .axis0_refcurrent_scale(scl0), .axis1_refcurrent_scale(scl1),
    .axis0_sense_range(rng0), .axis1_sense_range(rng1),
    .axis0_overcurrent_sel(oc0), .axis1_overcurrent_sel(oc1),
    .axis0_range_gain_factor(gn0), .axis1_range_gain_factor(gn1));

  ddc_host_model u_host (.clock(clock), .step(step), .sw(sw));

  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic chk_cnt(input int got, input int exp, input string msg);
    checked++;
    if (got != exp) begin
      num_errors++;
      $display("FAIL %0t %s got %0d exp %0d", $time, msg, got, exp);
    end
  endtask : chk_cnt

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(negedge clock);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clock);
    reg_wr    = 1'b0;
  endtask : wr

  // rvalid stands one cycle only, so look right after the read edge
  task automatic rd_chk(input logic [6:0] a, input logic [31:0] exp);
    @(negedge clock);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clock);
    reg_rd   = 1'b0;
    chk({31'h0, reg_rvalid}, 32'h1, "rvalid");
    chk(reg_rdata, exp, "rdata");
  endtask : rd_chk

  // step, then count edges until standstill shows
  task automatic idle_run(input int ax, input int thr);
    int k;
    u_host.pulse(ax);
    chk({31'h0, idle[ax]}, 32'h0, "idle after step");
    for (k = 1; k < 70; k++) begin
      @(posedge clock);
      #1;
      if (idle[ax] === 1'b1) break;
    end
    chk_cnt(k, thr, "idle delay");
  endtask : idle_run

  initial begin
    #100000;
    chk_cnt(0, 1, "timeout");
    stop_test;
  end

  initial begin
    reg_addr  = 7'h00;
    reg_wr    = 1'b0;
    reg_wdata = 32'h0;
    reg_rd    = 1'b0;
    repeat (3) @(negedge clock);
    rst_b = 1'b1;
    repeat (3) @(negedge clock);
    rd_chk(DRIVER_CONFIGURATION, 32'h0);
    wr(DRIVER_CONFIGURATION, 32'hffff_ffff);
    rd_chk(DRIVER_CONFIGURATION, 32'h0077_0fff);
    wr(7'h06, 32'h0);
    rd_chk(DRIVER_CONFIGURATION, 32'h0077_0fff);
    rd_chk(7'h06, 32'h0);
    // write then read in the very next cycle
    @(negedge clock);
    reg_addr  = DRIVER_CONFIGURATION;
    reg_wdata = 32'h00a5_0c3c;
    reg_wr    = 1'b1;
    @(negedge clock);
    reg_wr    = 1'b0;
    reg_rd    = 1'b1;
    @(negedge clock);
    reg_rd    = 1'b0;
    chk(reg_rdata, 32'h0025_0c3c, "read after write");
    for (int c = 0; c < 4; c++) begin
      logic [1:0] f;
      f = c[1:0];
      wr(DRIVER_CONFIGURATION, {22'h0, f, ~f, 2'h0, f, ~f});
      @(negedge clock);
      chk({28'h0, scl1, scl0}, {28'h0, f, f}, "scale");
      chk({24'h0, rng1, rng0, oc1, oc0},
          {24'h0, ~f, ~f, ~f, ~f}, "range");
      chk({12'h0, gn1, gn0},
          {12'h0, GAIN_X100[~f], GAIN_X100[~f]}, "gain");
    end
    // own left always high, so a lone switch must not halt
    for (int ax = 0; ax < 2; ax++) begin
      for (int i = 0; i < 16; i++) begin
        logic [3:0] v;
        logic       e;
        v = i[3:0];
        e = v[0] & (v[2] | (v[1] & v[3]));
        wr(DRIVER_CONFIGURATION, (ax == 1) ? {20'h0, v[1], v[0], 10'h0}
                                           : {26'h0, v[1], v[0], 4'h0});
        u_host.set_sw((ax == 1) ? {v[2], 1'b1, v[3], v[3]}
                                : {v[3], v[3], v[2], 1'b1});
        repeat (2) @(negedge clock);
        chk({30'h0, halt},
            (ax == 1) ? {30'h0, e, 1'b0} : {30'h0, 1'b0, e},
            "halt");
      end
    end
    u_host.set_sw(4'h0);
    wr(DRIVER_CONFIGURATION, 32'h0020_0000);
    idle_run(1, 4);
    idle_run(0, 16);
    u_host.pulse(1);
    @(negedge clock);
    idle_run(1, 4);
    wr(DRIVER_CONFIGURATION, 32'h0003_0000);
    idle_run(0, 2);
    stop_test;
  end
endmodule : tb_top
`default_nettype wire
